// *** hw/cpu_exec_pkg.sv ***
// constants, opcodes, states and carriers of the instruction execute block
package cpu_exec_pkg;
   localparam int MEM_AW = 7;
   localparam int MEM_BYTES = 128;
   localparam int CNT_W = 11;
   // flag positions in ccr
   localparam int CCR_I = 7;
   localparam int CCR_H = 5;
   localparam int CCR_N = 3;
   localparam int CCR_Z = 2;
   localparam int CCR_V = 1;
   localparam int CCR_C = 0;
   localparam logic [7:0] CCR_RESET = 8'h80;
   // apb byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_PC = 8'h08;
   localparam logic [7:0] OFS_FLAGS = 8'h0c;
   localparam logic [7:0] OFS_MADDR = 8'h10;
   localparam logic [7:0] OFS_MDATA = 8'h14;
   localparam logic [7:0] OFS_LAST = 8'h18;
   localparam logic [2:0] GPR_PAGE = 3'h1;
   localparam int CTRL_STEP = 0;
   localparam int CTRL_RUN = 1;
   localparam int CTRL_WAKE = 2;
   localparam int ST_BUSY = 0;
   localparam int ST_SLEEP = 1;
   localparam int ST_ILLEGAL = 2;
   localparam int ST_MOVCLS = 3;
   localparam int ST_OPC_POS = 8;
   // register roles
   localparam logic [2:0] SP_IDX = 3'h7;
   localparam logic [3:0] COUNT_IDX = 4'hc;
   localparam logic [2:0] SRC_IDX = 3'h5;
   localparam logic [2:0] DST_IDX = 3'h6;
   // first opcode bytes
   localparam logic [7:0] OPC_NOP = 8'h00;
   localparam logic [7:0] OPC_SLEEP = 8'h01;
   localparam logic [7:0] OPC_STC = 8'h02;
   localparam logic [7:0] OPC_LDC_R = 8'h03;
   localparam logic [7:0] OPC_ORC = 8'h04;
   localparam logic [7:0] OPC_XOR_FLAGS_IMM = 8'h05;
   localparam logic [7:0] OPC_AND_FLAGS_IMM = 8'h06;
   localparam logic [7:0] OPC_LDC_I = 8'h07;
   localparam logic [7:0] OPC_ADDW = 8'h09;
   localparam logic [7:0] OPC_MOVB = 8'h0c;
   localparam logic [7:0] OPC_MOVW = 8'h0d;
   localparam logic [7:0] OPC_ADDX = 8'h0e;
   localparam logic [7:0] OPC_DAA = 8'h0f;
   localparam logic [7:0] OPC_SHR = 8'h11;
   localparam logic [7:0] OPC_DAS = 8'h1f;
   localparam logic [7:0] OPC_DIV = 8'h51;
   localparam logic [7:0] OPC_RTS = 8'h54;
   localparam logic [7:0] OPC_RTE = 8'h56;
   localparam logic [7:0] OPC_JSR = 8'h5f;
   localparam logic [7:0] OPC_BMOVE = 8'h7b;
   localparam logic [3:0] HI_BRANCH = 4'h4;
   localparam logic [3:0] HI_MOV = 4'h6;
   localparam logic [3:0] HI_MOVI = 4'hf;
   // execution states, on-chip memory
   localparam logic [CNT_W-1:0] ST_SHORT = 11'h002;
   localparam logic [CNT_W-1:0] ST_BRANCH = 11'h004;
   localparam logic [CNT_W-1:0] ST_CALL = 11'h008;
   localparam logic [CNT_W-1:0] ST_RET = 11'h008;
   localparam logic [CNT_W-1:0] ST_XRET = 11'h00a;
   localparam logic [CNT_W-1:0] ST_DIV = 11'h00c;
   localparam logic [CNT_W-1:0] ST_MOVE_BASE = 11'h008;
   localparam logic [CNT_W-1:0] ST_COPY_FIRST = 11'h007;

   typedef enum logic [4:0] {
      OP_NOP = 5'h00, OP_SLEEP = 5'h01, OP_STC = 5'h02, OP_LDC_R = 5'h03,
      OP_LDC_I = 5'h04, OP_ORC = 5'h05, OP_XOR_FLAGS_IMM = 5'h06, OP_AND_FLAGS_IMM = 5'h07,
      OP_RTS = 5'h08, OP_RTE = 5'h09, OP_JSR = 5'h0a, OP_BMOVE = 5'h0b,
      OP_DAA = 5'h0c, OP_DAS = 5'h0d, OP_DIV = 5'h0e, OP_ADDW = 5'h0f,
      OP_ADDX = 5'h10, OP_BCC = 5'h11, OP_SHLR = 5'h12, OP_SHAR = 5'h13,
      OP_MOVCLS = 5'h14, OP_BAD = 5'h15
   } op_e;

   typedef struct packed {
      logic [MEM_BYTES-1:0][7:0] mem;
      logic [7:0][15:0] r;
      logic [15:0] pc;
      logic [7:0] ccr;
      logic run;
      logic sleep;
      logic illegal;
      logic movcls;
      logic busy;
      op_e op;
      logic [15:0] iw;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] total;
      logic [CNT_W-1:0] last;
      logic [MEM_AW-1:0] maddr;
      logic [31:0] prdata;
      logic slverr;
   } cpu_s;
endpackage : cpu_exec_pkg

// *** hw/cpu_exec.sv ***
// execute unit for call/return, flag register ops, sleep, block move and decode
// How it works
// RQ1 - indirect call: stack down two, push next pc, load pc from word at aa; 8 states
// RQ2 - return: pc from stack top, stack up two, flags kept; 8 states
// RQ3 - exception return pops flags then pc, stack up two each; 10 states
// RQ4 - sleep enters sleep mode, flags kept, 2 states
// RQ5 - flag register load, store, and, or, xor take 2 states each
// RQ6 - block move copies bytes source to dest while count nonzero; zero does nothing
// RQ7 - block move occupies 4n+8 states, n the initial count byte
// RQ8 - state counts are those of on-chip memory, which is all this unit has
// RQ9 - word add sets half-carry on carry out of bit 11
// RQ10 - extended add keeps zero flag on zero result, clears it otherwise
// RQ11 - decimal add adjust sets carry when adjustment carries, else clear; decimal subtract adjust sets carry when upper digit adjusted
// RQ12 - unsigned divide sets negative flag when divisor negative
// RQ13 - unsigned divide sets zero flag when divisor is zero
// RQ14 - primary operation chosen from opcode bits 15 to 8
// RQ15 - shared first bytes split by bit 7 of the instruction word
// RQ16 - peripheral moves and push/pop decode as ordinary moves
// RQ17 - branch aliases share encodings with always, never, carry clear, carry set
// RQ18 - no-operation only advances pc by two, 2 states
`timescale 1ns/1ps
`default_nettype none
module cpu_exec
   import cpu_exec_pkg::*;
(
   input wire logic pclk, // 250 MHz clock
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error, unmapped address
   output logic sleep_mode, // core is asleep
   output logic exec_busy // instruction in execution
);
   cpu_s q;
   cpu_s d;
   logic [7:0] opc;
   logic [7:0] b2;
   logic [7:0] rs8;
   logic [7:0] rd8;
   logic [15:0] pcn;
   logic [15:0] sp;
   logic [16:0] sum17;
   logic [12:0] sum13;
   logic [8:0] sum9;
   logic [7:0] adj;
   logic [15:0] quot;
   logic [15:0] rem;
   logic [15:0] fetch;
   op_e dec;
   logic acc;
   logic wr_ok;

   function automatic logic [7:0] get8(input logic [7:0][15:0] r, input logic [3:0] i);
      get8 = i[3] ? r[i[2:0]][7:0] : r[i[2:0]][15:8];
   endfunction : get8

   function automatic logic [7:0][15:0] put8(input logic [7:0][15:0] r, input logic [3:0] i,
                                             input logic [7:0] v);
      put8 = r;
      if (i[3]) begin
         put8[i[2:0]][7:0] = v;
      end else begin
         put8[i[2:0]][15:8] = v;
      end
   endfunction : put8

   function automatic logic [15:0] rdw(input logic [MEM_BYTES-1:0][7:0] m, input logic [15:0] a);
      rdw = {m[a[MEM_AW-1:0]], m[MEM_AW'(a + 16'h0001)]};
   endfunction : rdw

   function automatic logic take(input logic [3:0] cc, input logic [7:0] f);
      logic nv;
      nv = f[CCR_N] ^ f[CCR_V];
      unique case (cc)
         4'h0: take = 1'b1;
         4'h1: take = 1'b0;
         4'h2: take = !(f[CCR_C] | f[CCR_Z]);
         4'h3: take = f[CCR_C] | f[CCR_Z];
         4'h4: take = !f[CCR_C];
         4'h5: take = f[CCR_C];
         4'h6: take = !f[CCR_Z];
         4'h7: take = f[CCR_Z];
         4'h8: take = !f[CCR_V];
         4'h9: take = f[CCR_V];
         4'ha: take = !f[CCR_N];
         4'hb: take = f[CCR_N];
         4'hc: take = !nv;
         4'hd: take = nv;
         4'he: take = !(f[CCR_Z] | nv);
         4'hf: take = f[CCR_Z] | nv;
      endcase
   endfunction : take

   // RQ14 first byte decode
   function automatic op_e decode(input logic [15:0] w);
      decode = OP_BAD;
      if (w[15:12] == HI_BRANCH) begin
         // RQ17 aliases same codes
         decode = OP_BCC;
      end else if (w[15:12] == HI_MOV || w[15:12] == HI_MOVI || w[15:8] == OPC_MOVB
                   || w[15:8] == OPC_MOVW) begin
         // RQ16 moves share class
         decode = OP_MOVCLS;
      end else begin
         unique case (w[15:8])
            OPC_NOP: decode = OP_NOP;
            OPC_SLEEP: decode = OP_SLEEP;
            OPC_STC: decode = OP_STC;
            OPC_LDC_R: decode = OP_LDC_R;
            OPC_LDC_I: decode = OP_LDC_I;
            OPC_ORC: decode = OP_ORC;
            OPC_XOR_FLAGS_IMM: decode = OP_XOR_FLAGS_IMM;
            OPC_AND_FLAGS_IMM: decode = OP_AND_FLAGS_IMM;
            OPC_RTS: decode = OP_RTS;
            OPC_RTE: decode = OP_RTE;
            OPC_JSR: decode = OP_JSR;
            OPC_BMOVE: decode = OP_BMOVE;
            OPC_DAA: decode = OP_DAA;
            OPC_DAS: decode = OP_DAS;
            OPC_DIV: decode = OP_DIV;
            OPC_ADDW: decode = OP_ADDW;
            OPC_ADDX: decode = OP_ADDX;
            // RQ15 bit 7 splits pair
            OPC_SHR: decode = w[7] ? OP_SHAR : OP_SHLR;
            default: decode = OP_BAD;
         endcase
      end
   endfunction : decode

   assign acc = psel & penable;
   assign pready = acc;
   assign prdata = q.prdata;
   assign pslverr = acc & q.slverr;
   assign sleep_mode = q.sleep;
   assign exec_busy = q.busy;

   always_comb begin
      d = q;
      opc = q.iw[15:8];
      b2 = q.iw[7:0];
      rs8 = get8(q.r, b2[7:4]);
      rd8 = get8(q.r, b2[3:0]);
      pcn = q.pc + 16'h0002;
      sp = q.r[SP_IDX];
      sum17 = {1'b0, q.r[b2[2:0]]} + {1'b0, q.r[b2[6:4]]};
      sum13 = {1'b0, q.r[b2[2:0]][11:0]} + {1'b0, q.r[b2[6:4]][11:0]};
      sum9 = {1'b0, rd8} + {1'b0, rs8} + {8'h00, q.ccr[CCR_C]};
      quot = 16'h0000;
      rem = 16'h0000;
      adj = 8'h00;
      fetch = rdw(q.mem, q.pc);
      dec = decode(fetch);
      wr_ok = acc & pwrite & !q.busy;
      // apb read data captured in setup phase
      if (psel && !penable) begin
         d.prdata = 32'h0000_0000;
         d.slverr = 1'b0;
         if (paddr[7:5] == GPR_PAGE) begin
            d.prdata = {16'h0000, q.r[paddr[4:2]]};
         end else begin
            unique case (paddr)
               OFS_CTRL: d.prdata[CTRL_RUN] = q.run;
               OFS_STATUS: d.prdata = {16'h0000, opc, 4'h0, q.movcls, q.illegal, q.sleep, q.busy};
               OFS_PC: d.prdata = {16'h0000, q.pc};
               OFS_FLAGS: d.prdata = {24'h000000, q.ccr};
               OFS_MADDR: d.prdata = {25'h0000000, q.maddr};
               OFS_MDATA: d.prdata = {24'h000000, q.mem[q.maddr]};
               OFS_LAST: d.prdata = {21'h000000, q.last};
               default: d.slverr = 1'b1;
            endcase
         end
      end
      if (acc && pwrite) begin
         if (paddr == OFS_CTRL) begin
            d.run = pwdata[CTRL_RUN];
            if (pwdata[CTRL_WAKE]) begin
               d.sleep = 1'b0;
            end
         end
         if (paddr == OFS_STATUS && pwdata[ST_ILLEGAL]) begin
            d.illegal = 1'b0;
         end
         if (paddr == OFS_STATUS && pwdata[ST_MOVCLS]) begin
            d.movcls = 1'b0;
         end
      end
      if (wr_ok) begin
         if (paddr[7:5] == GPR_PAGE) begin
            d.r[paddr[4:2]] = pwdata[15:0];
         end
         unique case (paddr)
            OFS_PC: d.pc = pwdata[15:0];
            OFS_FLAGS: d.ccr = pwdata[7:0];
            OFS_MADDR: d.maddr = pwdata[MEM_AW-1:0];
            OFS_MDATA: d.mem[q.maddr] = pwdata[7:0];
            default: d.ccr = d.ccr;
         endcase
      end
      if (!q.busy) begin
         if (!q.sleep && (q.run || (wr_ok && paddr == OFS_CTRL && pwdata[CTRL_STEP]))) begin
            d.busy = 1'b1;
            d.iw = fetch;
            d.op = dec;
            d.cnt = 11'h001;
            unique case (dec)
               OP_JSR, OP_RTS: d.total = ST_CALL;
               OP_RTE: d.total = ST_XRET;
               OP_BCC: d.total = ST_BRANCH;
               OP_DIV: d.total = ST_DIV;
               // RQ7 4n+8 states
               OP_BMOVE: d.total = ST_MOVE_BASE + {1'b0, get8(q.r, COUNT_IDX), 2'b00};
               default: d.total = ST_SHORT;
            endcase
         end
      end else if (q.cnt != q.total) begin
         d.cnt = q.cnt + 11'h001;
         // RQ6 one byte per four states
         if (q.op == OP_BMOVE && q.cnt >= ST_COPY_FIRST && q.cnt[1:0] == 2'b11
             && get8(q.r, COUNT_IDX) != 8'h00) begin
            d.mem[q.r[DST_IDX][MEM_AW-1:0]] = q.mem[q.r[SRC_IDX][MEM_AW-1:0]];
            d.r[SRC_IDX] = q.r[SRC_IDX] + 16'h0001;
            d.r[DST_IDX] = q.r[DST_IDX] + 16'h0001;
            d.r = put8(d.r, COUNT_IDX, get8(q.r, COUNT_IDX) - 8'h01);
         end
      end else begin
         // RQ8 counts match on-chip timing
         d.busy = 1'b0;
         d.last = q.total;
         d.pc = pcn;
         unique case (q.op)
            // RQ18 pc advance only
            OP_NOP: d.pc = pcn;
            // RQ4 enter sleep
            OP_SLEEP: d.sleep = 1'b1;
            // RQ5 flag register transfers and logic
            OP_STC: d.r = put8(q.r, b2[3:0], q.ccr);
            OP_LDC_R: d.ccr = rd8;
            OP_LDC_I: d.ccr = b2;
            OP_ORC: d.ccr = q.ccr | b2;
            OP_XOR_FLAGS_IMM: d.ccr = q.ccr ^ b2;
            OP_AND_FLAGS_IMM: d.ccr = q.ccr & b2;
            // RQ1 push pc, load indirect
            OP_JSR: begin
               d.r[SP_IDX] = sp - 16'h0002;
               d.mem[MEM_AW'(sp - 16'h0002)] = pcn[15:8];
               d.mem[MEM_AW'(sp - 16'h0001)] = pcn[7:0];
               d.pc = rdw(q.mem, {8'h00, b2});
            end
            // RQ2 pop pc
            OP_RTS: begin
               d.pc = rdw(q.mem, sp);
               d.r[SP_IDX] = sp + 16'h0002;
            end
            // RQ3 pop flags then pc
            OP_RTE: begin
               d.ccr = q.mem[sp[MEM_AW-1:0]];
               d.pc = rdw(q.mem, sp + 16'h0002);
               d.r[SP_IDX] = sp + 16'h0004;
            end
            OP_BMOVE: d.pc = q.pc + 16'h0004;
            OP_BCC: begin
               if (take(opc[3:0], q.ccr)) begin
                  d.pc = pcn + {{8{b2[7]}}, b2};
               end
            end
            // RQ9 half-carry from bit 11
            OP_ADDW: begin
               d.r[b2[2:0]] = sum17[15:0];
               d.ccr[CCR_H] = sum13[12];
               d.ccr[CCR_N] = sum17[15];
               d.ccr[CCR_Z] = sum17[15:0] == 16'h0000;
               d.ccr[CCR_V] = (q.r[b2[2:0]][15] == q.r[b2[6:4]][15]) && (sum17[15] != q.r[b2[2:0]][15]);
               d.ccr[CCR_C] = sum17[16];
            end
            // RQ10 zero flag sticky on zero
            OP_ADDX: begin
               d.r = put8(q.r, b2[3:0], sum9[7:0]);
               d.ccr[CCR_Z] = (sum9[7:0] == 8'h00) ? q.ccr[CCR_Z] : 1'b0;
               d.ccr[CCR_N] = sum9[7];
               d.ccr[CCR_V] = (rd8[7] == rs8[7]) && (sum9[7] != rd8[7]);
               d.ccr[CCR_C] = sum9[8];
            end
            // RQ11 carry from adjustment
            OP_DAA, OP_DAS: begin
               if (rd8[3:0] > 4'h9 || q.ccr[CCR_H]) begin
                  adj[3:0] = 4'h6;
               end
               if (rd8 > 8'h99 || q.ccr[CCR_C]) begin
                  adj[7:4] = 4'h6;
               end
               sum9 = (q.op == OP_DAA) ? {1'b0, rd8} + {1'b0, adj} : {1'b0, rd8} - {1'b0, adj};
               d.r = put8(q.r, b2[3:0], sum9[7:0]);
               d.ccr[CCR_C] = (q.op == OP_DAA) ? sum9[8] : adj[6];
               d.ccr[CCR_N] = sum9[7];
               d.ccr[CCR_Z] = sum9[7:0] == 8'h00;
            end
            // RQ12 RQ13 divisor flags
            OP_DIV: begin
               d.ccr[CCR_N] = rs8[7];
               d.ccr[CCR_Z] = rs8 == 8'h00;
               if (rs8 != 8'h00) begin
                  quot = q.r[b2[2:0]] / {8'h00, rs8};
                  rem = q.r[b2[2:0]] % {8'h00, rs8};
                  d.r[b2[2:0]] = {rem[7:0], quot[7:0]};
               end
            end
            OP_SHLR, OP_SHAR: begin
               adj = {(q.op == OP_SHAR) & rd8[7], rd8[7:1]};
               d.r = put8(q.r, b2[3:0], adj);
               d.ccr[CCR_C] = rd8[0];
               d.ccr[CCR_V] = 1'b0;
               d.ccr[CCR_N] = adj[7];
               d.ccr[CCR_Z] = adj == 8'h00;
            end
            OP_MOVCLS: d.movcls = 1'b1;
            OP_BAD: d.illegal = 1'b1;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.ccr <= CCR_RESET;
         q.op <= OP_NOP;
      end else begin
         q <= d;
      end
   end
endmodule : cpu_exec
`default_nettype wire

// *** tb/cpu_exec_properties.sv ***
// concurrent checks on the execute block ports
`timescale 1ns/1ps
`default_nettype none
module cpu_exec_properties
   import cpu_exec_pkg::*;
(
   input wire logic pclk, // clock
   input wire logic presetn, // reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb address
   input wire logic [31:0] pwdata, // apb write data
   input wire logic [31:0] prdata, // apb read data
   input wire logic pready, // apb ready
   input wire logic pslverr, // apb error
   input wire logic sleep_mode, // asleep
   input wire logic exec_busy // executing
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [10:0] run_q;
   logic [10:0] run_d;
   logic acc;
   logic ctrl_wr;
   assign acc = psel && penable;
   assign ctrl_wr = acc && pwrite && paddr == OFS_CTRL;
   // length of the current busy stretch
   always_comb begin
      run_d = exec_busy ? run_q + 11'h001 : 11'h000;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_q <= 11'h000;
      end else begin
         run_q <= run_d;
      end
   end
   sequence step_req;
      ctrl_wr && pwdata[CTRL_STEP] && !exec_busy && !sleep_mode;
   endsequence
   sequence busy_pair;
      exec_busy [*2];
   endsequence
   ready_follow_a: assert property (pready == acc) else $error("pready not tied to access phase");
   err_access_a: assert property (pslverr |-> acc) else $error("pslverr outside access phase");
   unmapped_err_a: assert property (acc && paddr == 8'h40 |-> pslverr) else $error("unmapped access not refused");
   mapped_ok_a: assert property (acc && paddr[1:0] == 2'b00 && (paddr <= OFS_LAST || paddr inside {[8'h20:8'h3c]})
      |-> !pslverr) else $error("error on a mapped register");
   rdata_hold_a: assert property ($changed(prdata) |-> $past(psel && !penable)) else $error("prdata moved");
   step_start_a: assert property (step_req |=> busy_pair) else $error("step did not start execution");
   states_even_a: assert property ($fell(exec_busy) |-> run_q >= 11'd2 && !run_q[0])
      else $error("odd or short state count");
   busy_bound_a: assert property (run_q <= 11'd1028) else $error("busy longer than longest move");
   sleep_keep_a: assert property (sleep_mode && !(ctrl_wr && pwdata[CTRL_WAKE]) |=> sleep_mode)
      else $error("sleep left without wake");
   asleep_idle_a: assert property (sleep_mode && !exec_busy |=> !exec_busy) else $error("ran while asleep");
   sleep_entry_a: assert property ($rose(sleep_mode) |-> $past(exec_busy)) else $error("sleep without instr");
   wake_up_a: assert property (sleep_mode && ctrl_wr && pwdata[CTRL_WAKE] |=> !sleep_mode)
      else $error("wake write ignored");
endmodule : cpu_exec_properties
bind cpu_exec cpu_exec_properties chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .sleep_mode(sleep_mode), .exec_busy(exec_busy));
`default_nettype wire

// *** tb/apb_host.sv ***
// apb host model issuing register traffic to the execute block
`timescale 1ns/1ps
`default_nettype none
module apb_host
   import cpu_exec_pkg::*;
(
   input wire logic pclk, // clock
   input wire logic pready, // slave ready
   input wire logic [31:0] prdata, // read data
   input wire logic pslverr, // slave error
   output logic psel, // select
   output logic penable, // access phase
   output logic pwrite, // direction
   output logic [7:0] paddr, // address
   output logic [31:0] pwdata // write data
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   // request held until pready is seen high at a rising edge
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
      output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
endmodule : apb_host
`default_nettype wire

// *** tb/cpu_control_flow_ccr_ops_decode_test.sv ***
// self-checking bench for the execute block
`timescale 1ns/1ps
`default_nettype none
module cpu_control_flow_ccr_ops_decode_test
   import cpu_exec_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, sleep_mode, exec_busy, e;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   int err_count = 0;
   int compares = 0;
   always #2 pclk = ~pclk;
   apb_host hst (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
   cpu_exec dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep_mode(sleep_mode),
      .exec_busy(exec_busy));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      hst.xfer(1'b1, a, d, q, e);
   endtask : wr
   task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      hst.xfer(1'b0, a, 32'h0, q, e);
      chk(what, exp, q);
   endtask : rchk
   task automatic wmem(input logic [7:0] a, input logic [7:0] b);
      wr(OFS_MADDR, {24'h0, a});
      wr(OFS_MDATA, {24'h0, b});
   endtask : wmem
   // place one word at a, step it and count busy cycles
   task automatic exec(input logic [7:0] a, input logic [15:0] iw, input int n);
      int k;
      wmem(a, iw[15:8]);
      wmem(a + 8'h01, iw[7:0]);
      wr(OFS_PC, {24'h0, a});
      wr(OFS_CTRL, 32'h1);
      k = 0;
      @(negedge pclk);
      while (exec_busy === 1'b1 && k < 1100) begin
         k++;
         @(negedge pclk);
      end
      chk("busy states", n, k);
      rchk("last count", OFS_LAST, n);
   endtask : exec
   task automatic reset_state;
      rchk("flags", OFS_FLAGS, {24'h0, CCR_RESET});
      rchk("pc", OFS_PC, 32'h0);
      hst.xfer(1'b0, 8'h40, 32'h0, q, e);
      chk("unmapped err", 32'h1, {31'h0, e});
      $display("reset state done");
   endtask : reset_state
   task automatic flag_ops;
      logic [15:0] iw [7] = '{16'h070f, 16'h0480, 16'h06a5, 16'h052b, 16'h020c, 16'h0700, 16'h030c};
      logic [7:0] fx [7] = '{8'h0f, 8'h8f, 8'h85, 8'hae, 8'hae, 8'h00, 8'hae};
      for (int i = 0; i < 7; i++) begin
         exec(8'h00, iw[i], 2);
         rchk("flags", OFS_FLAGS, {24'h0, fx[i]});
      end
      rchk("stored flags", 8'h30, 32'hae);
      $display("flag ops done");
   endtask : flag_ops
   task automatic call_return;
      wr(8'h3c, 32'h40);
      wmem(8'h30, 8'h00);
      wmem(8'h31, 8'h50);
      exec(8'h00, 16'h5f30, 8);
      rchk("call pc", OFS_PC, 32'h50);
      rchk("call sp", 8'h3c, 32'h3e);
      wr(OFS_MADDR, 32'h3f);
      rchk("pushed pc", OFS_MDATA, 32'h02);
      exec(8'h50, 16'h5400, 8);
      rchk("return pc", OFS_PC, 32'h2);
      rchk("return sp", 8'h3c, 32'h40);
      rchk("return flags", OFS_FLAGS, 32'hae);
      wmem(8'h40, 8'h2d);
      wmem(8'h42, 8'h00);
      wmem(8'h43, 8'h24);
      exec(8'h00, 16'h5600, 10);
      rchk("xret pc", OFS_PC, 32'h24);
      rchk("xret sp", 8'h3c, 32'h44);
      rchk("xret flags", OFS_FLAGS, 32'h2d);
      $display("call return done");
   endtask : call_return
   task automatic sleep_entry;
      exec(8'h00, 16'h0100, 2);
      chk("asleep", 32'h1, {31'h0, sleep_mode});
      rchk("sleep flags", OFS_FLAGS, 32'h2d);
      wr(OFS_CTRL, 32'h1);
      @(negedge pclk);
      chk("idle asleep", 32'h0, {31'h0, exec_busy});
      rchk("pc asleep", OFS_PC, 32'h2);
      wr(OFS_CTRL, 32'h4);
      @(negedge pclk);
      chk("awake", 32'h0, {31'h0, sleep_mode});
      $display("sleep done");
   endtask : sleep_entry
   task automatic block_move;
      wr(8'h30, 32'h3);
      wr(8'h34, 32'h60);
      wr(8'h38, 32'h70);
      for (int i = 0; i < 3; i++) begin
         wmem(8'h60 + 8'(i), 8'ha1 + 8'(i));
      end
      wmem(8'h63, 8'hee);
      exec(8'h00, 16'h7b5c, 20);
      for (int i = 0; i < 4; i++) begin
         wr(OFS_MADDR, 32'h70 + i);
         rchk("moved byte", OFS_MDATA, (i < 3) ? 32'ha1 + i : 32'h0);
      end
      rchk("count", 8'h30, 32'h0);
      exec(8'h00, 16'h7b5c, 8);
      rchk("source", 8'h34, 32'h63);
      rchk("dest", 8'h38, 32'h73);
      $display("block move done");
   endtask : block_move
   task automatic decode_misc;
      logic [15:0] iw [4] = '{16'h4004, 16'h4104, 16'h4404, 16'h4504};
      logic [31:0] px [4] = '{32'h16, 32'h12, 32'h12, 32'h16};
      exec(8'h10, 16'h0000, 2);
      rchk("nop pc", OFS_PC, 32'h12);
      rchk("nop flags", OFS_FLAGS, 32'h2d);
      for (int i = 0; i < 4; i++) begin
         exec(8'h10, iw[i], 4);
         rchk("branch pc", OFS_PC, px[i]);
      end
      wr(8'h28, 32'h1234);
      exec(8'h00, 16'h5192, 12);
      hst.xfer(1'b0, OFS_FLAGS, 32'h0, q, e);
      chk("divide n z", 32'h4, q & 32'h0c);
      rchk("divide rd", 8'h28, 32'h1234);
      $display("decode misc done");
   endtask : decode_misc
   task automatic arith_flags;
      wr(OFS_FLAGS, 32'h0);
      wr(8'h20, 32'h0fff);
      wr(8'h24, 32'h8001);
      wr(8'h2c, 32'hffa0);
      exec(8'h00, 16'h0f0b, 2);
      rchk("adjust flags", OFS_FLAGS, 32'h05);
      exec(8'h00, 16'h0910, 2);
      rchk("word add flags", OFS_FLAGS, 32'h28);
      exec(8'h00, 16'h0e93, 2);
      rchk("extend flags", OFS_FLAGS, 32'h21);
      exec(8'h00, 16'h5110, 12);
      rchk("divide flags", OFS_FLAGS, 32'h29);
      exec(8'h00, 16'h1181, 2);
      exec(8'h00, 16'h1101, 2);
      rchk("shifted", 8'h24, 32'h6001);
      exec(8'h00, 16'h6c00, 2);
      rchk("move class", OFS_STATUS, 32'h6c08);
      wmem(8'h00, 8'h01);
      wr(OFS_PC, 32'h0);
      wr(OFS_CTRL, 32'h2);
      repeat (6) @(negedge pclk);
      chk("run asleep", 32'h1, {31'h0, sleep_mode});
      rchk("run pc", OFS_PC, 32'h2);
      wr(OFS_CTRL, 32'h4);
      $display("arith flags done");
   endtask : arith_flags
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : wrap_up
   initial begin
      repeat (40000) @(posedge pclk);
      err_count++;
      wrap_up();
   end
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      reset_state();
      flag_ops();
      call_return();
      sleep_entry();
      block_move();
      decode_misc();
      arith_flags();
      wrap_up();
   end
endmodule : cpu_control_flow_ccr_ops_decode_test
`default_nettype wire
